//--- uci_defs.svh
// Offsets, field positions, reset values and timing counts of the command/event block
//
// How it works
// - Two-bit overrun counter starts at zero, counts every overrun, wraps at three.
// - Software setting the owner change request raises the owner change flag.
// - Owner change request clears after changeover and stays clear until requested again.
// - A descriptor found during bulk processing sets bulk filled again.
// - A descriptor found during control processing sets control filled again.
// - Soft reset command forces suspend, clears operational state, blocks register access.
// - Hardware clears the soft reset command itself, within ten milliseconds.
// - Soft reset leaves the root hub alone and drives no port reset.
// - Event flags are set by hardware, owner change by a command write, and cleared by software.
// - Hub change flag sets when hub or any of four port statuses change.
// - Frame wrap flag sets whenever the frame number top bit changes.
// - Fatal error flag always reads zero; its enable and disable writes are ignored.
// - Resume flag sets when resume signalling is seen on any downstream port.
// - Frame start flag sets on every start-of-frame event from frame management.
// - Done list written flag sets after the done list pointer reaches memory.
// - Overrun flag sets whenever the list processor reports a scheduling overrun.
// - Interrupt requested when a flag, its enable and the master enable are set.
// - Enable and disable bit positions match the event positions in the status word.
// - Writing one to the enable register sets that enable; zero leaves it.
// - Writing one to the disable register clears that enable, master included.
// - Functional state codes reset 00, resume 01, operational 10, suspend 11.
// - Routing bit picks normal or management interrupt and survives soft reset.
`ifndef UCI_DEFS_SVH
`define UCI_DEFS_SVH

`define UCI_OFF_CMD        8'h08
`define UCI_OFF_STAT       8'h0c
`define UCI_OFF_IEN        8'h10
`define UCI_OFF_IDIS       8'h14
`define UCI_OFF_HCCA       8'h18

`define UCI_CMD_SRST       0
`define UCI_CMD_CTRL_FILL  1
`define UCI_CMD_BULK_FILL  2
`define UCI_CMD_OWNER_REQ  3
`define UCI_CMD_CNT_LO     16
`define UCI_CMD_CNT_HI     17

`define UCI_EV_OVERRUN     0
`define UCI_EV_DONE_WR     1
`define UCI_EV_FRAME_START 2
`define UCI_EV_RESUME      3
`define UCI_EV_FATAL       4
`define UCI_EV_FRAME_WRAP  5
`define UCI_EV_HUB_CHG     6
`define UCI_EV_OWNER       30
`define UCI_EV_MASTER      31

`define UCI_FLAG_MASK      32'h4000_006f
`define UCI_EN_MASK        32'hc000_006f
`define UCI_HCCA_MASK      32'hffff_ff00
`define UCI_REG_RESET      32'h0000_0000

`define UCI_CLK_PERIOD_NS  8
`define UCI_SRST_MAX_NS    10000000

`endif

//--- uci_pkg.sv
// Types shared by the command/event block
package uci_pkg;

	typedef enum logic [1:0] {
		UCI_FS_RESET   = 2'b00,
		UCI_FS_RESUME  = 2'b01,
		UCI_FS_OPER    = 2'b10,
		UCI_FS_SUSPEND = 2'b11
	} uci_fs_t;

	typedef enum logic [1:0] {
		UCI_SR_IDLE = 2'b00,
		UCI_SR_RUN  = 2'b01,
		UCI_SR_DONE = 2'b11
	} uci_sr_st_t;

	typedef struct packed {
		logic       overrun;
		logic       done_written;
		logic       frame_start;
		logic [3:0] resume;
		logic       hub_chg;
		logic [3:0] port_chg;
		logic       frame_msb;
	} uci_evt_t;

	typedef struct packed {
		logic bulk_head;
		logic bulk_td;
		logic ctrl_head;
		logic ctrl_td;
	} uci_list_t;

endpackage

//--- uci_flag_bank.sv
// Bank of sticky bits with per-bit set and clear, set beating clear
`timescale 1ns/1ns
`include "uci_defs.svh"

module uci_flag_bank #(
	parameter logic [31:0] MASK = `UCI_FLAG_MASK
) (
	input  wire logic        sys_clk,  // Controller clock
	input  wire logic        rst_b,    // Synchronous reset, active low
	input  wire logic        wipe,     // Soft reset clear
	input  wire logic [31:0] set,      // Hardware or write-one set
	input  wire logic [31:0] clr,      // Write-one clear
	output logic      [31:0] flags_ff  // Current bits
);

	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_bit
			if (MASK[i]) begin : g_live
				// Local bit so each output bit has one continuous driver only
				logic bit_ff;
				always_ff @(posedge sys_clk) begin
					if (!rst_b || wipe)
						bit_ff <= 1'b0;
					else if (set[i])
						bit_ff <= 1'b1;
					else if (clr[i])
						bit_ff <= 1'b0;
				end
				assign flags_ff[i] = bit_ff;
			end else begin : g_dead
				// Unimplemented or reserved positions read zero
				assign flags_ff[i] = 1'b0;
			end
		end
	endgenerate

endmodule // uci_flag_bank

//--- uci_srst_timer.sv
// Soft reset sequencer holding the reset for a fixed count of cycles
`timescale 1ns/1ns

module uci_srst_timer #(
	parameter int unsigned LEN = 16
) (
	input  wire logic sys_clk,  // Controller clock
	input  wire logic rst_b,    // Synchronous reset, active low
	input  wire logic start,    // Begin a soft reset
	output logic      busy_ff,  // Soft reset in progress
	output logic      done_ff   // One-cycle pulse at completion
);

	localparam int CW = $clog2(LEN + 1);
	localparam logic [CW-1:0] LAST = CW'(LEN - 1);

	uci_pkg::uci_sr_st_t st_ff;
	logic [CW-1:0]       cnt_ff;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st_ff   <= uci_pkg::UCI_SR_IDLE;
			cnt_ff  <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			unique case (st_ff)
				uci_pkg::UCI_SR_IDLE: begin
					if (start) begin
						st_ff   <= uci_pkg::UCI_SR_RUN;
						cnt_ff  <= '0;
						busy_ff <= 1'b1;
					end
				end
				uci_pkg::UCI_SR_RUN: begin
					if (cnt_ff == LAST) begin
						st_ff   <= uci_pkg::UCI_SR_DONE;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff + 1'b1;
					end
				end
				uci_pkg::UCI_SR_DONE: st_ff <= uci_pkg::UCI_SR_IDLE;
				default: st_ff <= uci_pkg::UCI_SR_IDLE;
			endcase
		end
	end

endmodule // uci_srst_timer

//--- uci_cmd_irq.sv
// Command, event status and interrupt control of the host controller
`timescale 1ns/1ns
`include "uci_defs.svh"

module uci_cmd_irq #(
	parameter int unsigned SRST_MAX_CYC = `UCI_SRST_MAX_NS / `UCI_CLK_PERIOD_NS
) (
	input  wire logic                sys_clk,             // Controller clock, 125 MHz
	input  wire logic                rst_b,               // Hardware reset, active low
	input  wire logic                reg_wr_en,           // Register write strobe
	input  wire logic                reg_rd_en,           // Register read strobe
	input  wire logic [7:0]          reg_addr,            // Register byte offset
	input  wire logic [31:0]         reg_wdata,           // Write data
	output logic      [31:0]         reg_rdata_ff,        // Read data
	output logic                     reg_rvalid_ff,       // Read data valid pulse
	input  wire uci_pkg::uci_evt_t   evt,                 // Hardware events
	input  wire uci_pkg::uci_list_t  list,                // List processor status
	input  wire logic                owner_change_done,   // Changeover complete pulse
	input  wire logic                fs_wr_en,            // Functional state write
	input  wire logic [1:0]          fs_wdata,            // New functional state
	input  wire logic                irq_routing_wr_en,   // Routing bit write
	input  wire logic                irq_routing_wdata,   // New routing bit
	output logic                     bulk_go_ff,          // Start bulk list pulse
	output logic                     ctrl_go_ff,          // Start control list pulse
	output uci_pkg::uci_fs_t         functional_state_ff, // Functional state
	output logic                     irq_routing_ff,      // Interrupt routing
	output logic                     soft_reset_busy_ff,  // Soft reset in progress
	output logic [31:0]              comm_area_base_ff,   // Communication area base
	output logic                     irq_int_ff,          // Normal interrupt request
	output logic                     irq_smi_ff           // Management interrupt request
);

	// ************************************************************
	// Register access decode
	// ************************************************************

	localparam int unsigned TIMER_LEN = SRST_MAX_CYC - 2;

	logic        srst_busy;
	logic        srst_done;
	logic        wr_ok;
	logic        wr_cmd;
	logic        wr_stat;
	logic        wr_ien;
	logic        wr_idis;
	logic        wr_hcca;
	logic [31:0] flags;
	logic [31:0] enables;

	logic        owner_req_ff;
	logic        bulk_list_filled_ff;
	logic        control_list_filled_ff;
	logic        soft_reset_cmd_ff;
	logic [1:0]  overrun_cnt_ff;
	logic        frame_msb_ff;
	logic        frame_msb_vld_ff;

	// Host bus access is refused while the soft reset runs
	assign wr_ok   = reg_wr_en && !srst_busy;
	assign wr_cmd  = wr_ok && (reg_addr == `UCI_OFF_CMD);
	assign wr_stat = wr_ok && (reg_addr == `UCI_OFF_STAT);
	assign wr_ien  = wr_ok && (reg_addr == `UCI_OFF_IEN);
	assign wr_idis = wr_ok && (reg_addr == `UCI_OFF_IDIS);
	assign wr_hcca = wr_ok && (reg_addr == `UCI_OFF_HCCA);

	// ************************************************************
	// Soft reset
	// ************************************************************

	uci_srst_timer #(
		.LEN (TIMER_LEN)
	) u_srst (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.start   (soft_reset_cmd_ff && !srst_busy && !srst_done),
		.busy_ff (srst_busy),
		.done_ff (srst_done)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			soft_reset_cmd_ff <= 1'b0;
		else if (srst_done)
			soft_reset_cmd_ff <= 1'b0;
		else if (wr_cmd && reg_wdata[`UCI_CMD_SRST])
			soft_reset_cmd_ff <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			soft_reset_busy_ff <= 1'b0;
		else
			soft_reset_busy_ff <= srst_busy;
	end

	// No root hub or port reset is driven from here on a soft reset
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			functional_state_ff <= uci_pkg::UCI_FS_RESET;
		else if (srst_busy)
			functional_state_ff <= uci_pkg::UCI_FS_SUSPEND;
		else if (fs_wr_en)
			functional_state_ff <= uci_pkg::uci_fs_t'(fs_wdata);
		else if (functional_state_ff == uci_pkg::UCI_FS_SUSPEND && |evt.resume)
			functional_state_ff <= uci_pkg::UCI_FS_RESUME;
	end

	// Routing is touched by hardware reset only
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			irq_routing_ff <= 1'b0;
		else if (irq_routing_wr_en && !srst_busy)
			irq_routing_ff <= irq_routing_wdata;
	end

	// ************************************************************
	// Command bits
	// ************************************************************

	always_ff @(posedge sys_clk) begin
		if (!rst_b || srst_busy)
			owner_req_ff <= 1'b0;
		else if (wr_cmd && reg_wdata[`UCI_CMD_OWNER_REQ])
			owner_req_ff <= 1'b1;
		else if (owner_change_done)
			owner_req_ff <= 1'b0;
	end

	// Descriptor found or software fill wins over the start-of-list clear
	always_ff @(posedge sys_clk) begin
		if (!rst_b || srst_busy)
			bulk_list_filled_ff <= 1'b0;
		else if (list.bulk_td || (wr_cmd && reg_wdata[`UCI_CMD_BULK_FILL]))
			bulk_list_filled_ff <= 1'b1;
		else if (list.bulk_head && bulk_list_filled_ff)
			bulk_list_filled_ff <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || srst_busy)
			control_list_filled_ff <= 1'b0;
		else if (list.ctrl_td || (wr_cmd && reg_wdata[`UCI_CMD_CTRL_FILL]))
			control_list_filled_ff <= 1'b1;
		else if (list.ctrl_head && control_list_filled_ff)
			control_list_filled_ff <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || srst_busy) begin
			bulk_go_ff <= 1'b0;
			ctrl_go_ff <= 1'b0;
		end else begin
			bulk_go_ff <= list.bulk_head && bulk_list_filled_ff;
			ctrl_go_ff <= list.ctrl_head && control_list_filled_ff;
		end
	end

	// Counts even when the overrun flag is already up
	always_ff @(posedge sys_clk) begin
		if (!rst_b || srst_busy)
			overrun_cnt_ff <= 2'h0;
		else if (evt.overrun)
			overrun_cnt_ff <= overrun_cnt_ff + 2'h1;
	end

	// ************************************************************
	// Event flags and enables
	// ************************************************************

	// First sample after reset only primes the comparison
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			frame_msb_ff     <= 1'b0;
			frame_msb_vld_ff <= 1'b0;
		end else begin
			frame_msb_ff     <= evt.frame_msb;
			frame_msb_vld_ff <= 1'b1;
		end
	end

	logic [31:0] flag_set;
	always_comb begin
		flag_set = 32'h0000_0000;
		flag_set[`UCI_EV_OVERRUN]     = evt.overrun;
		flag_set[`UCI_EV_DONE_WR]     = evt.done_written;
		flag_set[`UCI_EV_FRAME_START] = evt.frame_start;
		flag_set[`UCI_EV_RESUME]      = |evt.resume;
		flag_set[`UCI_EV_FRAME_WRAP]  = frame_msb_vld_ff && (evt.frame_msb != frame_msb_ff);
		flag_set[`UCI_EV_HUB_CHG]     = evt.hub_chg || (|evt.port_chg);
		flag_set[`UCI_EV_OWNER]       = wr_cmd && reg_wdata[`UCI_CMD_OWNER_REQ];
	end

	// Hardware sets, software write-one clears, set wins
	uci_flag_bank #(
		.MASK (`UCI_FLAG_MASK)
	) u_flags (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.wipe     (srst_busy),
		.set      (flag_set),
		.clr      (wr_stat ? reg_wdata : 32'h0000_0000),
		.flags_ff (flags)
	);

	// Same bit positions as the flags; unimplemented fatal bit is masked off
	uci_flag_bank #(
		.MASK (`UCI_EN_MASK)
	) u_enables (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.wipe     (srst_busy),
		.set      (wr_ien ? reg_wdata : 32'h0000_0000),
		.clr      (wr_idis ? reg_wdata : 32'h0000_0000),
		.flags_ff (enables)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_b || srst_busy)
			comm_area_base_ff <= `UCI_REG_RESET;
		else if (wr_hcca)
			comm_area_base_ff <= reg_wdata & `UCI_HCCA_MASK;
	end

	// ************************************************************
	// Interrupt request
	// ************************************************************

	logic irq_any;
	assign irq_any = enables[`UCI_EV_MASTER] && (|(flags & enables & `UCI_FLAG_MASK));

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			irq_int_ff <= 1'b0;
			irq_smi_ff <= 1'b0;
		end else begin
			irq_int_ff <= irq_any && !irq_routing_ff;
			irq_smi_ff <= irq_any && irq_routing_ff;
		end
	end

	// ************************************************************
	// Register read
	// ************************************************************

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_addr)
			`UCI_OFF_CMD: begin
				rd_mux[`UCI_CMD_SRST]                   = soft_reset_cmd_ff;
				rd_mux[`UCI_CMD_CTRL_FILL]              = control_list_filled_ff;
				rd_mux[`UCI_CMD_BULK_FILL]              = bulk_list_filled_ff;
				rd_mux[`UCI_CMD_OWNER_REQ]              = owner_req_ff;
				rd_mux[`UCI_CMD_CNT_HI:`UCI_CMD_CNT_LO] = overrun_cnt_ff;
			end
			`UCI_OFF_STAT: rd_mux = flags;
			`UCI_OFF_IEN,
			`UCI_OFF_IDIS: rd_mux = enables;
			`UCI_OFF_HCCA: rd_mux = comm_area_base_ff;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			reg_rdata_ff  <= `UCI_REG_RESET;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_rd_en;
			// Reads during a soft reset return zero
			reg_rdata_ff  <= (reg_rd_en && !srst_busy) ? rd_mux : `UCI_REG_RESET;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************

	logic [31:0] srst_len_ff;
	always_ff @(posedge sys_clk) begin
		if (!rst_b || !soft_reset_cmd_ff)
			srst_len_ff <= 32'h0000_0000;
		else
			srst_len_ff <= srst_len_ff + 32'h0000_0001;
	end

	a_overrun_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
		evt.overrun && !srst_busy |=> overrun_cnt_ff == $past(overrun_cnt_ff) + 2'h1)
		else $error("overrun counter did not advance");

	a_owner_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_cmd && reg_wdata[`UCI_CMD_OWNER_REQ] |=> flags[`UCI_EV_OWNER] && owner_req_ff)
		else $error("owner change flag not raised");

	a_owner_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
		owner_change_done && !(wr_cmd && reg_wdata[`UCI_CMD_OWNER_REQ]) |=> !owner_req_ff)
		else $error("owner request not cleared");

	a_bulk_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
		list.bulk_head && !srst_busy |=> bulk_go_ff == $past(bulk_list_filled_ff))
		else $error("bulk start does not follow filled bit");

	a_ctrl_refill: assert property (@(posedge sys_clk) disable iff (!rst_b)
		list.ctrl_td && !srst_busy ##1 !srst_busy |-> control_list_filled_ff)
		else $error("control filled bit not set by descriptor");

	a_srst_suspend: assert property (@(posedge sys_clk) disable iff (!rst_b)
		srst_busy |=> functional_state_ff == uci_pkg::UCI_FS_SUSPEND && $stable(irq_routing_ff))
		else $error("soft reset did not hold suspend");

	a_srst_bound: assert property (@(posedge sys_clk) disable iff (!rst_b)
		srst_len_ff <= SRST_MAX_CYC)
		else $error("soft reset ran too long");

	a_fatal_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!flags[`UCI_EV_FATAL] && !enables[`UCI_EV_FATAL])
		else $error("fatal error bit not zero");

	a_frame_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
		frame_msb_vld_ff && !srst_busy && evt.frame_msb != frame_msb_ff
		|=> flags[`UCI_EV_FRAME_WRAP])
		else $error("frame wrap flag missed");

	a_irq_master: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!enables[`UCI_EV_MASTER] |=> !irq_int_ff && !irq_smi_ff)
		else $error("interrupt without master enable");

	a_disable_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_idis && reg_wdata[`UCI_EV_MASTER] |=> !enables[`UCI_EV_MASTER] ##1 !irq_int_ff)
		else $error("disable write left master enable set");

endmodule // uci_cmd_irq

//--- test_uci_cmd_irq.sv
// Self-checking testbench of the command, event status and interrupt block
`timescale 1ns/1ns
`include "uci_defs.svh"

module test_uci_cmd_irq;
	// Long enough for a refused write and a blocked read inside the busy window
	localparam int SRST = 12;
	logic               sys_clk;
	logic               rst_b;
	logic               reg_wr_en;
	logic               reg_rd_en;
	logic [7:0]         reg_addr;
	logic [31:0]        reg_wdata;
	logic [31:0]        reg_rdata_ff;
	logic               reg_rvalid_ff;
	uci_pkg::uci_evt_t  evt;
	uci_pkg::uci_list_t list;
	logic               owner_change_done;
	logic               fs_wr_en;
	logic [1:0]         fs_wdata;
	logic               rt_wr;
	logic               rt_wd;
	logic               bulk_go_ff;
	logic               ctrl_go_ff;
	uci_pkg::uci_fs_t   fs_ff;
	logic               irq_routing_ff;
	logic               busy_ff;
	logic [31:0]        comm_base;
	logic               irq_int_ff;
	logic               irq_smi_ff;
	logic               fmsb;
	int                 n_mismatch;
	int                 num_checks;
	int                 cyc;
	int                 eb[7] = '{0, 1, 2, 3, 6, 6, 5};

	uci_cmd_irq #(.SRST_MAX_CYC(SRST)) DUT (
		.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
		.reg_rvalid_ff(reg_rvalid_ff), .evt(evt), .list(list),
		.owner_change_done(owner_change_done), .fs_wr_en(fs_wr_en), .fs_wdata(fs_wdata),
		.irq_routing_wr_en(rt_wr), .irq_routing_wdata(rt_wd), .bulk_go_ff(bulk_go_ff),
		.ctrl_go_ff(ctrl_go_ff), .functional_state_ff(fs_ff), .irq_routing_ff(irq_routing_ff),
		.soft_reset_busy_ff(busy_ff), .comm_area_base_ff(comm_base),
		.irq_int_ff(irq_int_ff), .irq_smi_ff(irq_smi_ff));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Bus and event tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			n_mismatch++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr_en <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
	endtask

	// Read data is sampled mid-cycle, where the registered answer has settled
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		@(negedge sys_clk);
		chk("rvalid", 32'h1, {31'h0, reg_rvalid_ff});
		chk(n, e, reg_rdata_ff & m);
	endtask

	task automatic ev_pulse(input uci_pkg::uci_evt_t e);
		e.frame_msb = fmsb;
		@(posedge sys_clk);
		evt <= e;
		@(posedge sys_clk);
		evt <= {12'h000, fmsb};
	endtask

	task automatic ls_pulse(input uci_pkg::uci_list_t l);
		@(posedge sys_clk);
		list <= l;
		@(posedge sys_clk);
		list <= '0;
		@(negedge sys_clk);
	endtask

	task automatic rt_set(input logic b);
		@(posedge sys_clk);
		rt_wr <= 1'b1;
		rt_wd <= b;
		@(posedge sys_clk);
		rt_wr <= 1'b0;
	endtask

	task automatic wait_busy(input logic b, output int n);
		n = 0;
		@(negedge sys_clk);
		while (busy_ff !== b && n < 4 * SRST) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		rdc("cmd rst", `UCI_OFF_CMD, 32'hffffffff, 32'h0);
		rdc("stat rst", `UCI_OFF_STAT, 32'hffffffff, 32'h0);
		rdc("ien rst", `UCI_OFF_IEN, 32'hffffffff, 32'h0);
		rdc("hcca rst", `UCI_OFF_HCCA, 32'hffffffff, 32'h0);
		wr(`UCI_OFF_HCCA, 32'hffffffff);
		rdc("hcca", `UCI_OFF_HCCA, 32'hffffffff, 32'hffffff00);
		chk("hcca out", 32'hffffff00, comm_base);
		wr(8'h20, 32'hffffffff);
		rdc("unmapped", 8'h20, 32'hffffffff, 32'h0);
		wr(`UCI_OFF_IEN, 32'hffffffff);
		rdc("ien set", `UCI_OFF_IEN, 32'hffffffff, 32'hc000006f);
		rdc("idis read", `UCI_OFF_IDIS, 32'hffffffff, 32'hc000006f);
		wr(`UCI_OFF_IDIS, 32'h80000011);
		rdc("ien clr", `UCI_OFF_IEN, 32'hffffffff, 32'h4000006e);
		wr(`UCI_OFF_IEN, 32'h0);
		rdc("ien zero", `UCI_OFF_IEN, 32'hffffffff, 32'h4000006e);
	endtask

	task automatic t_events;
		uci_pkg::uci_evt_t e;
		wr(`UCI_OFF_IEN, 32'hffffffff);
		for (int k = 0; k < 7; k++) begin
			e = '0;
			case (k)
				0: e.overrun = 1'b1;
				1: e.done_written = 1'b1;
				2: e.frame_start = 1'b1;
				3: e.resume = 4'h4;
				4: e.hub_chg = 1'b1;
				5: e.port_chg = 4'h8;
				default: fmsb = ~fmsb;
			endcase
			@(negedge sys_clk);
			chk("irq idle", 32'h0, {31'h0, irq_int_ff});
			ev_pulse(e);
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk("irq int", 32'h1, {31'h0, irq_int_ff});
			wr(`UCI_OFF_STAT, 32'h0);
			rdc("flag", `UCI_OFF_STAT, 32'hffffffff, 32'h1 << eb[k]);
			wr(`UCI_OFF_STAT, 32'h1 << eb[k]);
			rdc("flag clr", `UCI_OFF_STAT, 32'hffffffff, 32'h0);
		end
		wr(`UCI_OFF_IDIS, 32'h4);
		e = '0;
		e.frame_start = 1'b1;
		ev_pulse(e);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("irq masked", 32'h0, {31'h0, irq_int_ff});
		rt_set(1'b1);
		wr(`UCI_OFF_IEN, 32'h4);
		repeat (2) @(negedge sys_clk);
		chk("irq smi", 32'h1, {31'h0, irq_smi_ff});
		chk("irq int off", 32'h0, {31'h0, irq_int_ff});
		wr(`UCI_OFF_IDIS, 32'h80000000);
		repeat (2) @(negedge sys_clk);
		chk("smi master", 32'h0, {31'h0, irq_smi_ff});
		wr(`UCI_OFF_STAT, 32'hffffffff);
	endtask

	task automatic t_count;
		uci_pkg::uci_evt_t e;
		e = '0;
		e.overrun = 1'b1;
		for (int k = 1; k <= 5; k++) begin
			ev_pulse(e);
			// One overrun was already counted in the event scenario
			rdc("overrun cnt", `UCI_OFF_CMD, 32'h30000, 32'((k + 1) % 4) << 16);
		end
	endtask

	task automatic t_owner;
		wr(`UCI_OFF_STAT, 32'hffffffff);
		wr(`UCI_OFF_CMD, 32'h8);
		rdc("owner flag", `UCI_OFF_STAT, 32'h40000000, 32'h40000000);
		rdc("owner req", `UCI_OFF_CMD, 32'h8, 32'h8);
		@(posedge sys_clk);
		owner_change_done <= 1'b1;
		@(posedge sys_clk);
		owner_change_done <= 1'b0;
		rdc("owner done", `UCI_OFF_CMD, 32'h8, 32'h0);
		rdc("owner stays", `UCI_OFF_CMD, 32'h8, 32'h0);
	endtask

	task automatic t_lists;
		logic [31:0] m;
		for (int j = 0; j < 2; j++) begin
			m = j ? 32'h2 : 32'h4;
			ls_pulse(j ? 4'b0010 : 4'b1000);
			chk("go empty", 32'h0, {31'h0, j ? ctrl_go_ff : bulk_go_ff});
			wr(`UCI_OFF_CMD, m);
			rdc("filled", `UCI_OFF_CMD, m, m);
			ls_pulse(j ? 4'b0010 : 4'b1000);
			chk("go", 32'h1, {31'h0, j ? ctrl_go_ff : bulk_go_ff});
			rdc("filled clr", `UCI_OFF_CMD, m, 32'h0);
			ls_pulse(j ? 4'b0001 : 4'b0100);
			rdc("filled td", `UCI_OFF_CMD, m, m);
			ls_pulse(j ? 4'b0010 : 4'b1000);
		end
	endtask

	task automatic t_srst;
		int n;
		uci_pkg::uci_evt_t e;
		@(posedge sys_clk);
		fs_wr_en <= 1'b1;
		fs_wdata <= 2'b10;
		@(posedge sys_clk);
		fs_wr_en <= 1'b0;
		@(negedge sys_clk);
		chk("fs oper", 32'h2, {30'h0, fs_ff});
		wr(`UCI_OFF_IEN, 32'hffffffff);
		wr(`UCI_OFF_CMD, 32'h1);
		wait_busy(1'b1, n);
		chk("busy", 32'h1, {31'h0, busy_ff});
		chk("fs susp", 32'h3, {30'h0, fs_ff});
		rt_set(1'b0);
		wr(`UCI_OFF_IEN, 32'hffffffff);
		// Reset command bit is still one here, so only the read block gives zero
		rdc("read busy", `UCI_OFF_CMD, 32'hffffffff, 32'h0);
		wait_busy(1'b0, n);
		chk("busy ends", 32'h1, {31'h0, n < SRST});
		repeat (2) @(posedge sys_clk);
		rdc("srst bit", `UCI_OFF_CMD, 32'hffffffff, 32'h0);
		rdc("ien wiped", `UCI_OFF_IEN, 32'hffffffff, 32'h0);
		rdc("hcca wiped", `UCI_OFF_HCCA, 32'hffffffff, 32'h0);
		chk("routing kept", 32'h1, {31'h0, irq_routing_ff});
		e = '0;
		e.resume = 4'h1;
		ev_pulse(e);
		@(negedge sys_clk);
		chk("fs resume", 32'h1, {30'h0, fs_ff});
	endtask

	// ****************************************
	// Main sequence and closing
	// ****************************************
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		{rst_b, reg_wr_en, reg_rd_en, owner_change_done, fs_wr_en, rt_wr, rt_wd, fmsb} = '0;
		{reg_addr, reg_wdata, fs_wdata} = '0;
		evt = '0;
		list = '0;
		{n_mismatch, num_checks, cyc} = '0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		t_events();
		t_count();
		t_owner();
		t_lists();
		t_srst();
		final_report();
	end
endmodule // test_uci_cmd_irq
